// ===== verilog/blf_cfg.svh
// constants for the boot-lock and fuse configuration block
// Behaviour
// - app bits both 1 means no restriction
// - app low bit 0 blocks stores to app
// - app high bit 0 blocks boot loads of app
// - app modes 3,4 mask irqs in app when vectors boot
// - boot bits both 1 means no restriction
// - boot low bit 0 blocks stores to boot
// - boot high bit 0 blocks app loads of boot
// - boot modes 3,4 mask irqs in boot when vectors app
// - three fuse bytes, programmed reads as zero
// - extended byte brownout bits default one
// - high byte layout and its defaults
// - low byte layout and its defaults
// - programmed clock-output fuse drives clock out
// - default boot size is the largest
// - default startup time is the longest
// - serial mode cannot change serial download fuse
// - chip erase leaves fuses unchanged
// - first memory lock programmed freezes fuses
// - fuses latched on programming entry, effect after
// - eeprom preserve acts immediately once programmed
// - fuses latched at power-up in normal mode
// - only chip erase and reset return lock bits to one
// - first memory lock blocks flash and eeprom programming
`ifndef BLF_CFG_SVH
`define BLF_CFG_SVH
`define BLF_EXT_DEFAULT   8'h07
`define BLF_HIGH_DEFAULT  8'h99
`define BLF_LOW_DEFAULT   8'h62
`define BLF_LOCK_DEFAULT  8'hFF
`define BLF_ERASED        1'b1
`define BLF_PROGRAMMED    1'b0
`define BLF_EXT_USED_MASK 8'h07
`define BLF_HI_EEPROM_PRESERVE     3
`define BLF_HI_SERIAL_DOWNLOAD_ENABLE      5
`define BLF_LO_CLOCK_OUTPUT_ENABLE      6
`define BLF_LK_LB1        0
`define BLF_LK_LB2        1
`define BLF_LK_APP_LO     2
`define BLF_LK_APP_HI     3
`define BLF_LK_BOOT_LO    4
`define BLF_LK_BOOT_HI    5
`define BLF_ADDR_EXT      2'h0
`define BLF_ADDR_HIGH     2'h1
`define BLF_ADDR_LOW      2'h2
`define BLF_ADDR_LOCK     2'h3
`define BLF_RD_FUSE       4'h0
`define BLF_RD_LATCH      4'h4
`define BLF_RD_LOCK_PIN   4'h8
`define BLF_RD_STATUS     4'hC
`define BLF_AV_LOCKS      4'h1
`endif

// ===== verilog/blf_pkg.sv
// types for the boot-lock and fuse configuration block
package blf_pkg;
	typedef struct packed {
		logic [7:0] ext;
		logic [7:0] high;
		logic [7:0] low;
	} blf_fuses_t;

	typedef enum logic [1:0] {
		BLF_SESSION_NORMAL,
		BLF_SESSION_PROG
	} blf_session_t;

	typedef struct packed {
		blf_fuses_t   nv;
		logic [7:0]   lock;
		blf_fuses_t   latched;
		blf_session_t session;
		logic         latched_valid;
		logic [31:0]  rdata;
		logic         rvalid;
	} blf_state_t;
endpackage : blf_pkg

// ===== verilog/blf_boot_lock_fuse.sv
// boot-lock checking, fuse storage and fuse latching
`timescale 1ns/1ps
`include "blf_cfg.svh"
module blf_boot_lock_fuse (
	input  wire logic        clk,
	input  wire logic        rst,
	// avalon-mm slave, word addressed
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// external programmer port
	input  wire logic        prog_mode_pin,
	input  wire logic        prog_serial,
	input  wire logic        prog_wr,
	input  wire logic [1:0]  prog_sel,
	input  wire logic [7:0]  prog_wdata,
	input  wire logic        prog_chip_erase,
	output logic      [7:0]  prog_rdata,
	output logic             prog_wr_refused,
	output logic             prog_mem_allowed,
	// cpu program-memory access check
	input  wire logic        cpu_exec_in_boot,
	input  wire logic        cpu_target_in_boot,
	input  wire logic        cpu_store,
	input  wire logic        cpu_load,
	input  wire logic        cpu_vectors_in_boot,
	input  wire logic        cpu_lock_set,
	input  wire logic [7:0]  cpu_lock_data,
	output logic             access_allowed,
	output logic             irq_disable,
	// latched fuse outputs
	input  wire logic        sys_clk_in,
	output logic      [23:0] fuse_latched,
	output logic             eeprom_preserve,
	output logic             clock_output_enable,
	output logic             clock_out
);
	blf_pkg::blf_state_t s_q;
	blf_pkg::blf_state_t s_d;
	logic [1:0] mode_sync_q;
	logic [1:0] ser_sync_q;

	// pins from the programmer come from outside the clock domain
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_sync_q <= 2'h0;
			ser_sync_q  <= 2'h0;
		end else begin
			mode_sync_q <= {mode_sync_q[0], prog_mode_pin};
			ser_sync_q  <= {ser_sync_q[0], prog_serial};
		end
	end

	logic in_prog;
	assign in_prog = mode_sync_q[1];

	// lock bits in use are the live lock byte, not a latched session copy
	logic app_lo;
	logic app_hi;
	logic boot_lo;
	logic boot_hi;
	logic fuses_frozen;
	assign app_lo       = s_q.lock[`BLF_LK_APP_LO];
	assign app_hi       = s_q.lock[`BLF_LK_APP_HI];
	assign boot_lo      = s_q.lock[`BLF_LK_BOOT_LO];
	assign boot_hi      = s_q.lock[`BLF_LK_BOOT_HI];
	assign fuses_frozen = (s_q.lock[`BLF_LK_LB1] == `BLF_PROGRAMMED);

	// access check by executing section and target section
	always_comb begin
		access_allowed = 1'b1;
		if (cpu_store && !cpu_target_in_boot && app_lo == `BLF_PROGRAMMED)
			access_allowed = 1'b0;
		if (cpu_load && cpu_exec_in_boot && !cpu_target_in_boot
			&& app_hi == `BLF_PROGRAMMED)
			access_allowed = 1'b0;
		if (cpu_store && cpu_target_in_boot && boot_lo == `BLF_PROGRAMMED)
			access_allowed = 1'b0;
		if (cpu_load && !cpu_exec_in_boot && cpu_target_in_boot
			&& boot_hi == `BLF_PROGRAMMED)
			access_allowed = 1'b0;
	end

	// modes 3 and 4 share a programmed high bit
	always_comb begin
		irq_disable = 1'b0;
		if (!cpu_exec_in_boot && cpu_vectors_in_boot && app_hi == `BLF_PROGRAMMED)
			irq_disable = 1'b1;
		if (cpu_exec_in_boot && !cpu_vectors_in_boot && boot_hi == `BLF_PROGRAMMED)
			irq_disable = 1'b1;
	end

	logic prog_mem_ok;
	assign prog_mem_ok = (s_q.lock[`BLF_LK_LB1] == `BLF_ERASED);

	// fuse write through the programmer, returns new fuse set
	function automatic blf_pkg::blf_fuses_t fuse_write(
		input blf_pkg::blf_fuses_t f,
		input logic [1:0]          sel,
		input logic [7:0]          wd,
		input logic                serial
	);
		blf_pkg::blf_fuses_t r;
		r = f;
		unique case (sel)
			`BLF_ADDR_EXT:  r.ext = wd & `BLF_EXT_USED_MASK;
			`BLF_ADDR_HIGH: begin
				r.high = wd;
				if (serial)
					r.high[`BLF_HI_SERIAL_DOWNLOAD_ENABLE] = f.high[`BLF_HI_SERIAL_DOWNLOAD_ENABLE];
			end
			`BLF_ADDR_LOW:  r.low = wd;
			default:        r = f;
		endcase
		return r;
	endfunction : fuse_write

	logic av_wr_locks;
	logic wr_fuse_req;
	logic wr_lock_req;
	assign av_wr_locks = avs_write && avs_address == `BLF_AV_LOCKS;
	assign wr_fuse_req = in_prog && prog_wr && prog_sel != `BLF_ADDR_LOCK;
	assign wr_lock_req = in_prog && prog_wr && prog_sel == `BLF_ADDR_LOCK;

	always_comb begin
		s_d        = s_q;
		s_d.rvalid = 1'b0;
		// session tracking and latching
		unique case (s_q.session)
			blf_pkg::BLF_SESSION_NORMAL: begin
				if (!s_q.latched_valid) begin
					s_d.latched       = s_q.nv;
					s_d.latched_valid = 1'b1;
				end
				if (in_prog) begin
					s_d.latched = s_q.nv;
					s_d.session = blf_pkg::BLF_SESSION_PROG;
				end
			end
			blf_pkg::BLF_SESSION_PROG: begin
				if (!in_prog) begin
					s_d.latched = s_q.nv;
					s_d.session = blf_pkg::BLF_SESSION_NORMAL;
				end
			end
			default: s_d.session = blf_pkg::BLF_SESSION_NORMAL;
		endcase
		// chip erase resets locks only, fuses stay
		if (in_prog && prog_chip_erase) begin
			s_d.lock = `BLF_LOCK_DEFAULT;
		end else begin
			if (wr_fuse_req && !fuses_frozen)
				s_d.nv = fuse_write(s_q.nv, prog_sel, prog_wdata, ser_sync_q[1]);
			// lock bits only ever go to programmed by writes
			if (wr_lock_req)
				s_d.lock = s_q.lock & prog_wdata;
			else if (cpu_lock_set)
				s_d.lock = s_q.lock & cpu_lock_data;
			else if (av_wr_locks)
				s_d.lock = s_q.lock & avs_writedata[7:0];
		end
		// register reads, one cycle of wait
		if (avs_read && !s_q.rvalid) begin
			s_d.rvalid = 1'b1;
			unique case (avs_address)
				`BLF_RD_FUSE:     s_d.rdata = {8'h00, s_q.nv.ext, s_q.nv.high, s_q.nv.low};
				`BLF_AV_LOCKS:    s_d.rdata = {24'h000000, s_q.lock};
				`BLF_RD_LATCH:    s_d.rdata = {8'h00, s_q.latched};
				`BLF_RD_STATUS:   s_d.rdata = {29'h00000000, fuses_frozen,
					prog_mem_ok, s_q.session == blf_pkg::BLF_SESSION_PROG};
				default:          s_d.rdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q.nv.ext        <= `BLF_EXT_DEFAULT;
			s_q.nv.high       <= `BLF_HIGH_DEFAULT;
			s_q.nv.low        <= `BLF_LOW_DEFAULT;
			s_q.lock          <= `BLF_LOCK_DEFAULT;
			s_q.latched.ext   <= `BLF_EXT_DEFAULT;
			s_q.latched.high  <= `BLF_HIGH_DEFAULT;
			s_q.latched.low   <= `BLF_LOW_DEFAULT;
			s_q.session       <= blf_pkg::BLF_SESSION_NORMAL;
			s_q.latched_valid <= 1'b0;
			s_q.rdata         <= 32'h00000000;
			s_q.rvalid        <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// writes finish at once; reads wait one cycle for registered data
	assign avs_waitrequest = avs_read && !s_q.rvalid;
	assign avs_readdata    = s_q.rdata;

	always_comb begin
		unique case (prog_sel)
			`BLF_ADDR_EXT:  prog_rdata = s_q.nv.ext;
			`BLF_ADDR_HIGH: prog_rdata = s_q.nv.high;
			`BLF_ADDR_LOW:  prog_rdata = s_q.nv.low;
			default:        prog_rdata = s_q.lock;
		endcase
	end
	assign prog_wr_refused  = wr_fuse_req && fuses_frozen;
	assign prog_mem_allowed = in_prog && prog_mem_ok;

	assign fuse_latched = s_q.latched;
	// preserve bypasses the latch once programmed
	assign eeprom_preserve = (s_q.latched.high[`BLF_HI_EEPROM_PRESERVE] == `BLF_PROGRAMMED)
		|| (s_q.nv.high[`BLF_HI_EEPROM_PRESERVE] == `BLF_PROGRAMMED);
	assign clock_output_enable = (s_q.latched.low[`BLF_LO_CLOCK_OUTPUT_ENABLE] == `BLF_PROGRAMMED);
	// gating a clock here is a model; a real chip uses a glitch-free cell
	assign clock_out = clock_output_enable & sys_clk_in;
endmodule : blf_boot_lock_fuse

// ===== sim/blf_boot_lock_fuse_properties.sv
// concurrent checks on the boot-lock and fuse block ports
`timescale 1ns/1ps
module blf_props (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        avs_read,
	input wire logic        avs_waitrequest,
	input wire logic        prog_mode_pin,
	input wire logic        prog_wr,
	input wire logic [1:0]  prog_sel,
	input wire logic [7:0]  prog_wdata,
	input wire logic        prog_chip_erase,
	input wire logic [7:0]  prog_rdata,
	input wire logic        prog_wr_refused,
	input wire logic        prog_mem_allowed,
	input wire logic        sys_clk_in,
	input wire logic [23:0] fuse_latched,
	input wire logic        eeprom_preserve,
	input wire logic        clock_output_enable,
	input wire logic        clock_out
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	// six cycles covers the two-flop sync and the refresh
	sequence in_prog;
		prog_mode_pin [*6];
	endsequence
	sequence in_norm;
		!prog_mode_pin [*6];
	endsequence
	read_wait_a: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("read answer timing wrong");
	clock_gate_a: assert property (clock_out == (clock_output_enable && sys_clk_in))
		else $error("clock output gating wrong");
	refuse_mem_a: assert property (prog_wr_refused |-> !prog_mem_allowed)
		else $error("memory programming open while frozen");
	refuse_hold_a: assert property (prog_wr_refused ##1 $stable(prog_sel) |-> $stable(prog_rdata))
		else $error("refused fuse write changed a fuse");
	prog_latch_a: assert property (in_prog ##1 prog_mode_pin |-> $stable(fuse_latched))
		else $error("latched fuses moved in programming mode");
	norm_latch_a: assert property (in_norm ##1 !prog_mode_pin |-> $stable(fuse_latched))
		else $error("latched fuses moved in normal mode");
	preserve_now_a: assert property (prog_wr && prog_sel == 2'h1 && !prog_wdata[3]
		&& prog_mem_allowed |-> ##[1:2] eeprom_preserve) else $error("preserve fuse late");
	erase_keep_a: assert property ((prog_chip_erase && !prog_wr && prog_sel != 2'h3)
		##1 $stable(prog_sel) |-> $stable(prog_rdata)) else $error("erase changed a fuse");
endmodule : blf_props
bind blf_boot_lock_fuse blf_props i_blf_props (.*);

// ===== sim/blf_prog_model.sv
// external programmer model driving the fuse programming port
`timescale 1ns/1ps
module blf_prog_model (
	input  wire logic       clk,
	output logic            prog_mode_pin,
	output logic            prog_serial,
	output logic            prog_wr,
	output logic      [1:0] prog_sel,
	output logic      [7:0] prog_wdata,
	output logic            prog_chip_erase
);
	initial {prog_mode_pin, prog_serial, prog_wr, prog_sel, prog_wdata, prog_chip_erase} = '0;
	task automatic mode(input logic m, input logic s);
		@(posedge clk);
		prog_mode_pin <= m;
		prog_serial   <= s;
	endtask : mode
	// e selects a chip erase pulse instead of a fuse or lock write
	task automatic put(input logic e, input logic [1:0] s, input logic [7:0] d);
		@(posedge clk);
		prog_sel        <= s;
		prog_wdata      <= d;
		prog_chip_erase <= e;
		prog_wr         <= !e;
		@(posedge clk);
		prog_wr         <= 1'b0;
		prog_chip_erase <= 1'b0;
		prog_wdata      <= ~d;
		@(negedge clk);
	endtask : put
endmodule : blf_prog_model

// ===== sim/blf_boot_lock_fuse_bench.sv
// self-checking bench for the boot-lock and fuse block
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin err_count++; \
	$display("[ERR] %s exp %h got %h", nm, e, s); end end
module blf_boot_lock_fuse_bench;
	logic        clk = 0, rst = 1, avs_read = 0, avs_write = 0, cpu_lock_set = 0;
	logic        sys_clk_in = 0, cpu_exec_in_boot = 0, cpu_target_in_boot = 0;
	logic        cpu_store = 0, cpu_load = 0, cpu_vectors_in_boot = 0;
	logic [3:0]  avs_address = '0;
	logic [7:0]  cpu_lock_data = '0, prog_wdata, prog_rdata;
	logic [31:0] avs_writedata = '0, avs_readdata, got;
	logic [1:0]  prog_sel;
	logic [23:0] fuse_latched;
	logic        avs_waitrequest, prog_mode_pin, prog_serial, prog_wr, prog_chip_erase;
	logic        prog_wr_refused, prog_mem_allowed, access_allowed, irq_disable;
	logic        eeprom_preserve, clock_output_enable, clock_out;
	int          err_count = 0, n_compared = 0;
	always #25 clk = ~clk;
	always @(posedge clk) sys_clk_in <= ~sys_clk_in;
	blf_boot_lock_fuse i_blf_boot_lock_fuse (.*);
	blf_prog_model i_blf_prog_model (.*);
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v);
		int n = 0;
		@(posedge clk);
		avs_address   <= a;
		avs_writedata <= v;
		avs_write     <= w;
		avs_read      <= !w;
		// the request stands until an edge samples waitrequest low
		@(posedge clk);
		while (avs_waitrequest !== 1'b0 && n < 20) begin
			n++;
			@(posedge clk);
		end
		if (n >= 20)
			err_count++;
		got = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
	endtask : bus
	// c is exec_boot, target_boot, store, load, vectors_boot; e is allowed, irq off
	task automatic cpu(input logic [4:0] c, input logic [1:0] e);
		@(posedge clk);
		{cpu_exec_in_boot, cpu_target_in_boot, cpu_store, cpu_load, cpu_vectors_in_boot} <= c;
		@(negedge clk);
		`CHK("cpu", e, {access_allowed, irq_disable})
	endtask : cpu
	task automatic give_verdict();
		$display("compared %0d mismatched %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : give_verdict
	initial begin
		#100us;
		err_count++;
		give_verdict();
	end
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		bus(1'b0, 4'h0, '0);
		`CHK("fuses", 32'h0007_9962, got)
		`CHK("copy", 24'h07_9962, fuse_latched)
		bus(1'b0, 4'h2, '0);
		`CHK("unmapped", 32'h0, got)
		cpu(5'b00100, 2'b10);
		cpu(5'b01010, 2'b10);
		bus(1'b1, 4'h1, 32'hFB);
		cpu(5'b10100, 2'b00);
		cpu(5'b10011, 2'b10);
		bus(1'b1, 4'h1, 32'hF7);
		cpu(5'b10010, 2'b00);
		cpu(5'b00011, 2'b11);
		@(posedge clk);
		cpu_lock_set  <= 1'b1;
		cpu_lock_data <= 8'hEF;
		cpu(5'b01100, 2'b00);
		@(posedge clk);
		cpu_lock_set  <= 1'b0;
		bus(1'b1, 4'h1, 32'hDF);
		bus(1'b0, 4'h1, '0);
		`CHK("lock", 32'hC3, got)
		cpu(5'b01010, 2'b00);
		cpu(5'b11010, 2'b11);
		i_blf_prog_model.mode(1'b1, 1'b0);
		repeat (4) @(posedge clk);
		i_blf_prog_model.put(1'b1, 2'h1, 8'h00);
		bus(1'b0, 4'h1, '0);
		`CHK("erased lock", 32'hFF, got)
		bus(1'b0, 4'h0, '0);
		`CHK("kept fuses", 32'h0007_9962, got)
		i_blf_prog_model.put(1'b0, 2'h1, 8'h91);
		`CHK("preserve", 1'b1, eeprom_preserve)
		`CHK("held copy", 24'h07_9962, fuse_latched)
		i_blf_prog_model.put(1'b0, 2'h2, 8'h22);
		i_blf_prog_model.mode(1'b1, 1'b1);
		repeat (4) @(posedge clk);
		i_blf_prog_model.put(1'b0, 2'h1, 8'hB1);
		i_blf_prog_model.put(1'b0, 2'h3, 8'hFE);
		i_blf_prog_model.put(1'b0, 2'h1, 8'h99);
		bus(1'b0, 4'h0, '0);
		`CHK("frozen", 32'h0007_9122, got)
		bus(1'b0, 4'hC, '0);
		`CHK("status", 32'h5, got)
		i_blf_prog_model.mode(1'b0, 1'b0);
		repeat (4) @(posedge clk);
		bus(1'b0, 4'h4, '0);
		`CHK("new copy", 32'h0007_9122, got)
		`CHK("clock out", 1'b1, clock_output_enable)
		give_verdict();
	end
endmodule : blf_boot_lock_fuse_bench
